// ---- design/bcb_unit.sv ----
// Purpose: carry-flag bit operations and control transfer, on axi4-lite
// Assumes: single clock, synchronous active-low reset
// Notes:   a write to the control word runs one operation
//
// Overview of operation
// RQ1 - carry becomes carry OR selected bit
// RQ2 - carry becomes carry OR inverted bit
// RQ3 - carry becomes carry XOR selected bit
// RQ4 - carry becomes carry XOR inverted bit
// RQ5 - carry takes the selected bit
// RQ6 - carry takes the inverted selected bit
// RQ7 - selected bit takes carry, carry unchanged
// RQ8 - selected bit takes inverted carry
// RQ9 - bit number is a 3-bit immediate
// RQ10 - always, never, Z, V, N branch tests
// RQ11 - unsigned tests on C and Z
// RQ12 - signed tests on N XOR V, Z
// RQ13 - jump loads target into program counter
// RQ14 - calls go to target, return resumes caller
// RQ15 - memory store reads, modifies, writes whole byte
// RQ16 - calls push next address, return pops it
// RQ17 - carry ops touch only the carry flag
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "bcb_map.svh"

module bcb_unit (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address channel
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  // write data channel
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // write response channel
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // read address channel
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  // read data channel
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  bcb_pkg::bcb_state_e state, next_state;      // execution phase
  bcb_pkg::bcb_cmd_s   cmd, next_cmd;          // current command
  bcb_pkg::bcb_ccr_s   ccr, next_ccr;          // flags
  logic [15:0]         pc, next_pc;            // program counter
  logic [15:0]         tgt, next_tgt;          // target or displacement
  logic [7:0]          opnd, next_opnd;        // fetched operand byte
  logic                taken, next_taken;      // last op moved pc
  logic                stk_err, next_stk_err;  // stack over/underflow
  logic [3:0]          sp, next_sp;            // stack depth
  logic [7:0]          greg [8];               // general byte registers
  logic [7:0]          next_greg [8];
  logic [7:0]          mem [16];               // operand memory
  logic [7:0]          next_mem [16];
  logic [15:0]         stk [8];                // return address stack
  logic [15:0]         next_stk [8];
  // axi side
  logic                aw_full, next_aw_full;  // address held
  logic [31:0]         aw_addr, next_aw_addr;
  logic                w_full, next_w_full;    // data held
  logic [31:0]         w_data, next_w_data;
  logic [3:0]          w_strb, next_w_strb;
  logic                next_awready, next_wready, next_arready;
  logic                next_bvalid, next_rvalid;
  logic [1:0]          next_bresp, next_rresp;
  logic [31:0]         next_rdata;
  // shared terms
  logic                busy;                   // an operation runs
  logic                do_wr;                  // a write completes
  logic                wr_go;                  // write is accepted
  logic                take;                   // branch condition
  logic [15:0]         pc_seq;                 // next sequential pc
  bcb_pkg::bcb_stat_s  stat;                   // status view

  assign busy   = (state != bcb_pkg::S_IDLE);
  assign do_wr  = aw_full & w_full & ~bvalid;
  assign wr_go  = do_wr & addr_ok(aw_addr) & ~busy;
  assign pc_seq = pc + `BCB_INSN_LEN;
  assign stat   = '{depth: sp, rsvd: 1'b0, stk_err: stk_err, taken: taken, busy: busy};

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // map check: aligned word at a known register
  function automatic logic addr_ok(input logic [31:0] a);
    logic hit;
    hit = (a == `BCB_ADDR_CTRL) || (a == `BCB_ADDR_CCR) || (a == `BCB_ADDR_PC) ||
          (a == `BCB_ADDR_TGT) || (a == `BCB_ADDR_STAT) ||
          ((a & `BCB_MASK_GREG) == `BCB_ADDR_GREG) ||
          ((a & `BCB_MASK_MEM) == `BCB_ADDR_MEM);
    return hit && ((a & `BCB_MASK_ALIGN) == 32'h0000_0000);
  endfunction

  // read view of a register; unmapped reads zero
  function automatic logic [31:0] rd_value(input logic [31:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (!addr_ok(a)) begin
      v = 32'h0000_0000;
    end else if (a == `BCB_ADDR_CTRL) begin
      v = cmd;
    end else if (a == `BCB_ADDR_CCR) begin
      v = {24'h00_0000, ccr};
    end else if (a == `BCB_ADDR_PC) begin
      v = {16'h0000, pc};
    end else if (a == `BCB_ADDR_TGT) begin
      v = {16'h0000, tgt};
    end else if (a == `BCB_ADDR_STAT) begin
      v = {24'h00_0000, stat};
    end else if ((a & `BCB_MASK_GREG) == `BCB_ADDR_GREG) begin
      v = {24'h00_0000, greg[a[4:2]]};
    end else begin
      v = {24'h00_0000, mem[a[5:2]]};
    end
    return v;
  endfunction

  // byte-lane merge under write strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // ------------------------------------------------------------
  // branch condition
  // ------------------------------------------------------------
  bcb_cond u_cond (
    .cc    (cmd.cc),
    .flags (ccr),
    .take  (take)
  );

  // ------------------------------------------------------------
  // axi handshake
  // ------------------------------------------------------------
  // channels are held independently; the response follows both
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (awvalid && awready) begin  // take address
      next_aw_full = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin  // take data
      next_w_full = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready) begin  // response taken
      next_bvalid = 1'b0;
    end
    if (do_wr) begin  // both halves present
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_go ? `BCB_RESP_OKAY : `BCB_RESP_SLVERR;
    end
    if (rvalid && rready) begin  // read data taken
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin  // answer read next cycle
      next_rvalid = 1'b1;
      next_rdata  = rd_value(araddr);
      next_rresp  = addr_ok(araddr) ? `BCB_RESP_OKAY : `BCB_RESP_SLVERR;
    end
    next_awready = ~next_aw_full;
    next_wready  = ~next_w_full;
    next_arready = ~next_rvalid;
  end

  // register the handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_full  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      arready <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `BCB_RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `BCB_RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full  <= next_w_full;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      awready <= next_awready;
      wready  <= next_wready;
      arready <= next_arready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // ------------------------------------------------------------
  // execution
  // ------------------------------------------------------------
  // idle takes register writes; load fetches; exec retires
  always_comb begin
    logic [31:0] wr_word;  // merged write value
    logic        sel;      // selected operand bit
    logic [7:0]  wb;       // byte written back
    wr_word       = merge(rd_value(aw_addr), w_data, w_strb);
    sel           = opnd[cmd.bitno];  // [RQ9]
    wb            = opnd;
    next_state    = state;
    next_cmd      = cmd;
    next_ccr      = ccr;
    next_pc       = pc;
    next_tgt      = tgt;
    next_opnd     = opnd;
    next_taken    = taken;
    next_stk_err  = stk_err;
    next_sp       = sp;
    next_greg     = greg;
    next_mem      = mem;
    next_stk      = stk;
    case (state)
      bcb_pkg::S_IDLE: begin
        if (wr_go && aw_addr == `BCB_ADDR_CTRL) begin  // start an operation
          next_cmd     = bcb_pkg::bcb_cmd_s'(wr_word);
          next_taken   = 1'b0;
          next_stk_err = 1'b0;
          next_state   = bcb_pkg::S_LOAD;
        end else if (wr_go && aw_addr == `BCB_ADDR_CCR) begin
          next_ccr      = bcb_pkg::bcb_ccr_s'(wr_word[7:0]);
          next_ccr.rsvd = 4'h0;
        end else if (wr_go && aw_addr == `BCB_ADDR_PC) begin
          next_pc = wr_word[15:0];
        end else if (wr_go && aw_addr == `BCB_ADDR_TGT) begin
          next_tgt = wr_word[15:0];
        end else if (wr_go && (aw_addr & `BCB_MASK_GREG) == `BCB_ADDR_GREG) begin
          next_greg[aw_addr[4:2]] = wr_word[7:0];
        end else if (wr_go && (aw_addr & `BCB_MASK_MEM) == `BCB_ADDR_MEM) begin
          next_mem[aw_addr[5:2]] = wr_word[7:0];
        end
      end
      bcb_pkg::S_LOAD: begin
        // whole byte read from register or memory
        next_opnd  = cmd.mem ? mem[cmd.maddr] : greg[cmd.ridx];  // [RQ15]
        next_state = bcb_pkg::S_EXEC;
      end
      bcb_pkg::S_EXEC: begin
        next_state = bcb_pkg::S_IDLE;
        next_pc    = pc_seq;
        case (cmd.op)
          // carry ops write only the c flag
          bcb_pkg::OP_CARRY_OR_BIT:           next_ccr.c = ccr.c | sel;   // [RQ1] [RQ17]
          bcb_pkg::OP_CARRY_OR_INVERTED_BIT:  next_ccr.c = ccr.c | ~sel;  // [RQ2] [RQ17]
          bcb_pkg::OP_CARRY_XOR_BIT:          next_ccr.c = ccr.c ^ sel;   // [RQ3] [RQ17]
          bcb_pkg::OP_CARRY_XOR_INVERTED_BIT: next_ccr.c = ccr.c ^ ~sel;  // [RQ4] [RQ17]
          bcb_pkg::OP_LOAD_BIT_TO_CARRY:      next_ccr.c = sel;           // [RQ5] [RQ17]
          bcb_pkg::OP_LOAD_INVERTED_BIT:      next_ccr.c = ~sel;          // [RQ6] [RQ17]
          bcb_pkg::OP_STORE_CARRY_TO_BIT,
          bcb_pkg::OP_STORE_INVERTED_CARRY: begin
            // modify one bit, write the whole byte back
            wb[cmd.bitno] = ccr.c ^ (cmd.op == bcb_pkg::OP_STORE_INVERTED_CARRY); // [RQ7] [RQ8]
            if (cmd.mem) begin
              next_mem[cmd.maddr] = wb;  // [RQ15]
            end else begin
              next_greg[cmd.ridx] = wb;
            end
          end
          bcb_pkg::OP_CONDITIONAL_BRANCH: begin
            if (take) begin  // [RQ10] [RQ11] [RQ12]
              next_pc    = pc_seq + tgt;
              next_taken = 1'b1;
            end
          end
          bcb_pkg::OP_ABSOLUTE_JUMP: begin
            next_pc    = tgt;  // [RQ13]
            next_taken = 1'b1;
          end
          bcb_pkg::OP_RELATIVE_SUBROUTINE,
          bcb_pkg::OP_ABSOLUTE_SUBROUTINE: begin
            if (sp == `BCB_STK_FULL) begin  // no room: refuse the call
              next_stk_err = 1'b1;
            end else begin
              next_stk[sp[2:0]] = pc_seq;  // [RQ16]
              next_sp           = sp + `BCB_STK_STEP;
              next_taken        = 1'b1;
              next_pc = (cmd.op == bcb_pkg::OP_ABSOLUTE_SUBROUTINE) ? tgt : pc_seq + tgt; // [RQ14]
            end
          end
          bcb_pkg::OP_SUBROUTINE_RETURN: begin
            if (sp == `BCB_STK_EMPTY) begin  // nothing to return to
              next_stk_err = 1'b1;
            end else begin
              next_pc    = stk[3'(sp - `BCB_STK_STEP)];  // [RQ14] [RQ16]
              next_sp    = sp - `BCB_STK_STEP;
              next_taken = 1'b1;
            end
          end
          default: next_pc = pc_seq;  // unknown op only advances
        endcase
      end
      default: next_state = bcb_pkg::S_IDLE;
    endcase
  end

  // register the core state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state   <= bcb_pkg::S_IDLE;
      cmd     <= '0;
      ccr     <= '0;
      pc      <= `BCB_PC_RST;
      tgt     <= 16'h0000;
      opnd    <= 8'h00;
      taken   <= 1'b0;
      stk_err <= 1'b0;
      sp      <= `BCB_STK_EMPTY;
      for (int i = 0; i < 8; i++) begin
        greg[i] <= 8'h00;
        stk[i]  <= 16'h0000;
      end
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 8'h00;
      end
    end else begin
      state   <= next_state;
      cmd     <= next_cmd;
      ccr     <= next_ccr;
      pc      <= next_pc;
      tgt     <= next_tgt;
      opnd    <= next_opnd;
      taken   <= next_taken;
      stk_err <= next_stk_err;
      sp      <= next_sp;
      greg    <= next_greg;
      mem     <= next_mem;
      stk     <= next_stk;
    end
  end

endmodule // bcb_unit

// ---- design/bcb_map.svh ----
// Purpose: address map, reset values and code points of the bit/branch unit
// Assumes: included by bare name; definitions only
// Notes:   all registers are one aligned 32-bit word
`ifndef BCB_MAP_SVH
`define BCB_MAP_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define BCB_ADDR_CTRL   32'h0000_0000
`define BCB_ADDR_CCR    32'h0000_0004
`define BCB_ADDR_PC     32'h0000_0008
`define BCB_ADDR_TGT    32'h0000_000C
`define BCB_ADDR_STAT   32'h0000_0010
`define BCB_ADDR_GREG   32'h0000_0020
`define BCB_MASK_GREG   32'hFFFF_FFE0
`define BCB_ADDR_MEM    32'h0000_0040
`define BCB_MASK_MEM    32'hFFFF_FFC0
`define BCB_MASK_ALIGN  32'h0000_0003

// ------------------------------------------------------------
// reset values and sizes
// ------------------------------------------------------------
`define BCB_PC_RST      16'h0000
`define BCB_INSN_LEN    16'h0002
`define BCB_STK_FULL    4'h8
`define BCB_STK_EMPTY   4'h0
`define BCB_STK_STEP    4'h1

// ------------------------------------------------------------
// axi responses
// ------------------------------------------------------------
`define BCB_RESP_OKAY   2'h0
`define BCB_RESP_SLVERR 2'h2

// ------------------------------------------------------------
// branch condition codes
// ------------------------------------------------------------
`define BCB_CC_ALWAYS   4'h0
`define BCB_CC_NEVER    4'h1
`define BCB_CC_HI       4'h2
`define BCB_CC_LS       4'h3
`define BCB_CC_CC       4'h4
`define BCB_CC_CS       4'h5
`define BCB_CC_NE       4'h6
`define BCB_CC_EQ       4'h7
`define BCB_CC_VC       4'h8
`define BCB_CC_VS       4'h9
`define BCB_CC_PL       4'hA
`define BCB_CC_MI       4'hB
`define BCB_CC_GE       4'hC
`define BCB_CC_LT       4'hD
`define BCB_CC_GT       4'hE
`define BCB_CC_LE       4'hF

`endif

// ---- design/bcb_pkg.sv ----
// Purpose: types shared by the bit/branch unit
// Assumes: used only through bcb_pkg::name
// Notes:   field order is msb first
package bcb_pkg;

  // ------------------------------------------------------------
  // operations
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_CARRY_OR_BIT            = 5'h00,
    OP_CARRY_OR_INVERTED_BIT   = 5'h01,
    OP_CARRY_XOR_BIT           = 5'h02,
    OP_CARRY_XOR_INVERTED_BIT  = 5'h03,
    OP_LOAD_BIT_TO_CARRY       = 5'h04,
    OP_LOAD_INVERTED_BIT       = 5'h05,
    OP_STORE_CARRY_TO_BIT      = 5'h06,
    OP_STORE_INVERTED_CARRY    = 5'h07,
    OP_CONDITIONAL_BRANCH      = 5'h08,
    OP_ABSOLUTE_JUMP           = 5'h09,
    OP_RELATIVE_SUBROUTINE     = 5'h0A,
    OP_ABSOLUTE_SUBROUTINE     = 5'h0B,
    OP_SUBROUTINE_RETURN       = 5'h0C
  } bcb_op_e;

  // command word written to the control register
  typedef struct packed {
    logic [11:0] rsvd;
    logic [3:0]  cc;
    logic [3:0]  maddr;
    logic [2:0]  ridx;
    logic        mem;
    logic [2:0]  bitno;
    bcb_op_e     op;
  } bcb_cmd_s;

  // condition code flags
  typedef struct packed {
    logic [3:0] rsvd;
    logic       n;
    logic       z;
    logic       v;
    logic       c;
  } bcb_ccr_s;

  // status word
  typedef struct packed {
    logic [3:0] depth;
    logic       rsvd;
    logic       stk_err;
    logic       taken;
    logic       busy;
  } bcb_stat_s;

  // execution states
  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_LOAD = 3'h2,
    S_EXEC = 3'h4
  } bcb_state_e;

endpackage

// ---- design/bcb_cond.sv ----
// Purpose: branch condition evaluation from the flags
// Assumes: flags come straight from the flag register
// Notes:   purely combinational
`timescale 1ns/1ps
`include "bcb_map.svh"

module bcb_cond (
  // condition select
  input  wire logic [3:0]         cc,
  // current flags
  input  wire bcb_pkg::bcb_ccr_s  flags,
  // branch decision
  output logic                    take
);

  // ------------------------------------------------------------
  // decision
  // ------------------------------------------------------------
  logic nv;  // signed less-than term

  // pick the tested relation for the condition code
  always_comb begin
    nv = flags.n ^ flags.v;
    case (cc)
      `BCB_CC_ALWAYS: take = 1'b1;                     // [RQ10]
      `BCB_CC_NEVER:  take = 1'b0;                     // [RQ10]
      `BCB_CC_HI:     take = ~(flags.c | flags.z);     // [RQ11]
      `BCB_CC_LS:     take = flags.c | flags.z;        // [RQ11]
      `BCB_CC_CC:     take = ~flags.c;                 // [RQ11]
      `BCB_CC_CS:     take = flags.c;                  // [RQ11]
      `BCB_CC_NE:     take = ~flags.z;                 // [RQ10]
      `BCB_CC_EQ:     take = flags.z;                  // [RQ10]
      `BCB_CC_VC:     take = ~flags.v;                 // [RQ10]
      `BCB_CC_VS:     take = flags.v;                  // [RQ10]
      `BCB_CC_PL:     take = ~flags.n;                 // [RQ10]
      `BCB_CC_MI:     take = flags.n;                  // [RQ10]
      `BCB_CC_GE:     take = ~nv;                      // [RQ12]
      `BCB_CC_LT:     take = nv;                       // [RQ12]
      `BCB_CC_GT:     take = ~(flags.z | nv);          // [RQ12]
      default:        take = flags.z | nv;             // [RQ12]
    endcase
  end

endmodule // bcb_cond

// ---- test/bcb_unit_chk.sv ----
// Purpose: bus-level checks on the bit/branch unit ports
// Assumes: bound to bcb_unit, one clock domain
// Notes:   watches design inputs and outputs only
`timescale 1ns/1ps

module bcb_unit_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // write side
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  // read side
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // handshake steps
  // ------------------------------------------------------------
  sequence wr_take_q;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take_q;
    arvalid && arready;
  endsequence
  // answers stand until taken
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  // answers come in time
  wr_resp_a: assert property (wr_take_q |-> ##[1:2] bvalid)
    else $error("write response late");
  rd_resp_a: assert property (rd_take_q |=> rvalid)
    else $error("read data late");
  // one transfer at a time
  ar_block_a: assert property (rvalid |-> !arready)
    else $error("address taken while data pending");
  aw_block_a: assert property (awvalid && awready |=> !awready ##1 (!awready || bvalid))
    else $error("write address reopened early");
  // response codes
  bresp_code_a: assert property (bvalid |-> bresp == 2'h0 || bresp == 2'h2)
    else $error("bad write response code");
  rd_err_zero_a: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
    else $error("refused read returns data");
  // idle after reset
  rst_idle_a: assert property (disable iff (1'b0)
    !aresetn |=> !awready && !wready && !arready && !bvalid && !rvalid)
    else $error("outputs active after reset");
endmodule // bcb_unit_chk

bind bcb_unit bcb_unit_chk bcb_unit_chk_inst (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready,
  .rdata, .rresp);

// ---- test/bcb_unit_tb_top.sv ----
// Purpose: self-checking bench for the bit/branch unit
// Assumes: axi4-lite master tasks, 125 MHz clock
// Notes:   every wait is bounded
`timescale 1ns/1ps

module bcb_unit_tb_top;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [31:0]       awaddr, wdata, araddr, rdata, d, p;
  logic [1:0]        bresp, rresp, r;
  int                mismatches, n_tests;
  bcb_pkg::bcb_cmd_s cm;

  bcb_unit bcb_unit_inst (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
    .rdata, .rresp);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // ------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic hang;
    mismatches++;
    give_verdict();
  endtask
  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) hang();
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) hang();
  endtask
  // start one operation, poll busy
  task automatic run(input logic [31:0] c);
    int n;
    wr(32'h00, c, r);
    cmp(32'(r), 32'h0);
    for (n = 0; n < 20; n++) begin
      rd(32'h10, d, r);
      if (d[0] === 1'b0) break;
    end
    if (n == 20) hang();
  endtask
  // expected branch decision, odd codes invert
  function automatic logic take(input logic [3:0] cc, input logic [3:0] f);
    logic s;
    s = f[3] ^ f[1];
    case (cc[3:1])
      3'h0: take = 1'b1;
      3'h1: take = !(f[0] | f[2]);
      3'h2: take = !f[0];
      3'h3: take = !f[2];
      3'h4: take = !f[1];
      3'h5: take = !f[3];
      3'h6: take = !s;
      default: take = !(f[2] | s);
    endcase
    take = take ^ cc[0];
  endfunction
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_carry;
    int o, c, b;
    logic [2:0] k;
    logic [7:0] v;
    logic [31:0] a;
    logic bb, e;
    for (o = 0; o < 6; o++)
      for (c = 0; c < 2; c++)
        for (b = 0; b < 2; b++) begin
          k = 3'(o * 3 + c + b);
          v = b ? (8'h01 << k) : ~(8'h01 << k);
          a = 32'(o[0] ? 64 + 4 * o : 32 + 4 * o);
          cm = '0;
          cm.op = bcb_pkg::bcb_op_e'(5'(o));
          cm.bitno = k;
          cm.mem = o[0];
          cm.ridx = 3'(o);
          cm.maddr = 4'(o);
          wr(32'h04, 32'h0E | 32'(c), r);
          wr(a, {24'h0, v}, r);
          run(cm);
          bb = 1'(b ^ o);
          e = o > 3 ? bb : o[1] ? 1'(c) ^ bb : 1'(c) | bb;
          rd(32'h04, d, r);
          cmp(d, {31'h7, e});
          rd(a, d, r);
          cmp(d, {24'h0, v});
        end
    $display("carry ops done");
  endtask
  task automatic t_store;
    int o, c;
    logic [2:0] k;
    logic [7:0] v;
    for (o = 6; o < 8; o++)
      for (c = 0; c < 2; c++) begin
        k = c ? 3'h5 : 3'h3;
        cm = '0;
        cm.op = bcb_pkg::bcb_op_e'(5'(o));
        cm.bitno = k;
        cm.mem = 1'b1;
        cm.maddr = 4'h2;
        wr(32'h04, 32'(c), r);
        wr(32'h48, 32'hA5, r);
        run(cm);
        v = 8'hA5 & ~(8'h01 << k) | (8'(c ^ (o - 6)) << k);
        rd(32'h48, d, r);
        cmp(d, {24'h0, v});
        rd(32'h04, d, r);
        cmp(d, 32'(c));
      end
    $display("store ops done");
  endtask
  task automatic t_branch;
    int cc, f;
    wr(32'h0C, 32'h10, r);
    for (cc = 0; cc < 16; cc++) begin
      cm = '0;
      cm.op = bcb_pkg::OP_CONDITIONAL_BRANCH;
      cm.cc = 4'(cc);
      for (f = 0; f < 16; f++) begin
        wr(32'h04, 32'(f), r);
        rd(32'h08, p, r);
        run(cm);
        rd(32'h08, d, r);
        cmp(d, {16'h0, p[15:0] + (take(4'(cc), 4'(f)) ? 16'h12 : 16'h02)});
      end
    end
    $display("branches done");
  endtask
  task automatic t_flow;
    cm = '0;
    wr(32'h0C, 32'h1230, r);
    cm.op = bcb_pkg::OP_ABSOLUTE_JUMP;
    run(cm);
    rd(32'h08, d, r);
    cmp(d, 32'h1230);
    wr(32'h0C, 32'h0400, r);
    cm.op = bcb_pkg::OP_ABSOLUTE_SUBROUTINE;
    run(cm);
    rd(32'h08, d, r);
    cmp(d, 32'h0400);
    wr(32'h0C, 32'h10, r);
    cm.op = bcb_pkg::OP_RELATIVE_SUBROUTINE;
    run(cm);
    rd(32'h08, d, r);
    cmp(d, 32'h0412);
    rd(32'h10, d, r);
    cmp(d, 32'h22);
    cm.op = bcb_pkg::OP_SUBROUTINE_RETURN;
    run(cm);
    rd(32'h08, d, r);
    cmp(d, 32'h0402);
    run(cm);
    rd(32'h08, d, r);
    cmp(d, 32'h1232);
    run(cm);
    rd(32'h10, d, r);
    cmp(d, 32'h04);
    $display("calls done");
  endtask
  // unmapped, unaligned and flag-width checks
  task automatic t_refuse;
    rd(32'h14, d, r);
    cmp({r, d[29:0]}, 32'h8000_0000);
    rd(32'h22, d, r);
    cmp(32'(r), 32'h2);
    wr(32'h18, 32'h1, r);
    cmp(32'(r), 32'h2);
    wr(32'h04, 32'hFF, r);
    rd(32'h04, d, r);
    cmp(d, 32'h0F);
    $display("refusals done");
  endtask

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    mismatches = 0;
    n_tests = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_refuse();
    t_carry();
    t_store();
    t_branch();
    t_flow();
    give_verdict();
  end
endmodule // bcb_unit_tb_top
